// File: src/ssc_far_end.sv
// logic board side with options: converter, processor acknowledge, keyboard,
// delaying option at E, inserting option at B, series option at C/D, slot F
// assumes the steering board registers every path by one cycle
`timescale 1ns/1ps
module ssc_far_end import ssc_pkg::*; #(
    parameter bit FIT_E = 1'b1,
    parameter bit FIT_B = 1'b1,
    parameter bit FIT_SER = 1'b1,
    parameter bit FIT_F = 1'b0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // steering board
    ssc_link_if.far lk,
    // received and typed characters in
    input wire logic [CHAR_W-1:0] rx_char_in,
    input wire logic rx_valid,
    input wire logic [CHAR_W-1:0] kbd_in,
    input wire logic kbd_valid,
    // consumed, transmitted and printed characters out
    output logic [CHAR_W-1:0] consumed_char,
    output logic consumed_valid,
    output logic [CHAR_W-1:0] tx_char,
    output logic tx_valid,
    output logic [CHAR_W-1:0] printed_char
);
    logic [CHAR_W-1:0] conv_char_r, conv_char_nxt, got_r, got_nxt;
    logic conv_av_r, conv_av_nxt, cb_q_r, cb_q_nxt, gotv_r, gotv_nxt;
    logic ack_r, ack_nxt;
    logic [7:0] ack_cnt_r, ack_cnt_nxt, e_cnt_r, e_cnt_nxt;
    logic e_busy_r, e_busy_nxt, e_out_r, e_out_nxt;
    logic b_q_r, b_q_nxt, b_cr_r, b_cr_nxt;
    ssc_ins_st_t st_r, st_nxt;
    logic [CHAR_W-1:0] kc_r, kc_nxt, so_r, so_nxt, tx_r, tx_nxt, pr_r, pr_nxt, fo_r, fo_nxt;
    logic ks_r, ks_nxt, ss_r, ss_nxt, lf_r, lf_nxt, txv_r, txv_nxt;

    always_comb begin
        // one avail per character; new character beats clear
        conv_av_nxt = ack_r ? 1'b0 : conv_av_r;
        conv_char_nxt = conv_char_r;
        if (rx_valid) begin
            conv_av_nxt = 1'b1;
            conv_char_nxt = rx_char_in;
        end
        cb_q_nxt = lk.cbuf_avail;
        got_nxt = got_r;
        gotv_nxt = 1'b0;
        ack_nxt = 1'b0;
        ack_cnt_nxt = ack_cnt_r;
        if (lk.cbuf_avail && !cb_q_r) begin
            got_nxt = lk.cbuf_char;
            gotv_nxt = 1'b1;
            ack_cnt_nxt = ACK_CYC;
        end else if (ack_cnt_r != 8'h00) begin
            ack_cnt_nxt = ack_cnt_r - 8'h01;
            ack_nxt = (ack_cnt_r == 8'h01);
        end
        e_busy_nxt = e_busy_r;
        e_cnt_nxt = e_cnt_r;
        e_out_nxt = e_out_r;
        if (lk.slot_ack) begin
            e_busy_nxt = 1'b0;
            e_out_nxt = 1'b0;
        end else if (lk.slot_da[SL_E] && !e_busy_r) begin
            e_busy_nxt = 1'b1;
            e_cnt_nxt = OPT_DELAY_CYC;
        end else if (e_busy_r && e_cnt_r != 8'h00) begin
            e_cnt_nxt = e_cnt_r - 8'h01;
            e_out_nxt = (e_cnt_r == 8'h01);
        end
        b_q_nxt = lk.slot_da[SL_B];
        b_cr_nxt = b_cr_r;
        st_nxt = st_r;
        case (st_r)
            INS_IDLE: if (lk.slot_da[SL_B] && !b_q_r) begin
                b_cr_nxt = (lk.slot_rx_char == CH_CR);
                st_nxt = INS_PASS;
            end
            INS_PASS: if (lk.slot_ack) st_nxt = b_cr_r ? INS_GAP : INS_IDLE;
            INS_GAP: st_nxt = INS_DRIVE;
            INS_DRIVE: if (lk.slot_ack) st_nxt = INS_IDLE;
            default: st_nxt = INS_IDLE;
        endcase
        kc_nxt = kbd_valid ? kbd_in : kc_r;
        ks_nxt = kbd_valid;
        so_nxt = so_r;
        ss_nxt = 1'b0;
        lf_nxt = 1'b0;
        if (lf_r) begin
            so_nxt = CH_LF;
            ss_nxt = 1'b1;
        end else if (lk.ser_in_strobe) begin
            so_nxt = lk.ser_in_char;
            ss_nxt = 1'b1;
            lf_nxt = (lk.ser_in_char == CH_CR);
        end
        tx_nxt = lk.lb_strobe ? lk.lb_char : tx_r;
        txv_nxt = lk.lb_strobe;
        pr_nxt = lk.phead_char;
        fo_nxt = lk.slotf_in_char ^ SUBST_MASK;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            conv_char_r <= CHAR_ZERO;
            conv_av_r <= 1'b0;
            cb_q_r <= 1'b0;
            got_r <= CHAR_ZERO;
            gotv_r <= 1'b0;
            ack_r <= 1'b0;
            ack_cnt_r <= 8'h00;
            e_busy_r <= 1'b0;
            e_cnt_r <= 8'h00;
            e_out_r <= 1'b0;
            b_q_r <= 1'b0;
            b_cr_r <= 1'b0;
            st_r <= INS_IDLE;
            kc_r <= CHAR_ZERO;
            ks_r <= 1'b0;
            so_r <= CHAR_ZERO;
            ss_r <= 1'b0;
            lf_r <= 1'b0;
            tx_r <= CHAR_ZERO;
            txv_r <= 1'b0;
            pr_r <= CHAR_ZERO;
            fo_r <= CHAR_ZERO;
        end else begin
            conv_char_r <= conv_char_nxt;
            conv_av_r <= conv_av_nxt;
            cb_q_r <= cb_q_nxt;
            got_r <= got_nxt;
            gotv_r <= gotv_nxt;
            ack_r <= ack_nxt;
            ack_cnt_r <= ack_cnt_nxt;
            e_busy_r <= e_busy_nxt;
            e_cnt_r <= e_cnt_nxt;
            e_out_r <= e_out_nxt;
            b_q_r <= b_q_nxt;
            b_cr_r <= b_cr_nxt;
            st_r <= st_nxt;
            kc_r <= kc_nxt;
            ks_r <= ks_nxt;
            so_r <= so_nxt;
            ss_r <= ss_nxt;
            lf_r <= lf_nxt;
            tx_r <= tx_nxt;
            txv_r <= txv_nxt;
            pr_r <= pr_nxt;
            fo_r <= fo_nxt;
        end
    end

    // B drives line feed, converter held off
    assign lk.conv_oe = (st_r != INS_DRIVE);
    assign lk.conv_char = conv_char_r;
    assign lk.conv_avail = conv_av_r;
    assign lk.slot_drv_oe = {FIT_B && st_r == INS_DRIVE, 3'b000};
    assign lk.slot_drv_char = {CH_LF, CHAR_ZERO, CHAR_ZERO, CHAR_ZERO};
    assign lk.slot_occupied_divert_line_n = {
        ~(FIT_B && (st_r == INS_PASS || st_r == INS_DRIVE)), 2'b11, ~FIT_E};
    assign lk.chain_strobe_out_n = {~FIT_B, 2'b11, ~(FIT_E && e_out_r)};
    assign lk.char_consumed_ack = ack_r;
    assign lk.cbuf_out_char = got_r;
    assign lk.slotf_out_char = fo_r;
    assign lk.slotf_fit_n = ~FIT_F;
    assign lk.kbd_char = kc_r;
    assign lk.kbd_strobe = ks_r;
    assign lk.ser_fit_n = ~FIT_SER;
    assign lk.ser_out_char = so_r;
    assign lk.ser_out_strobe = ss_r;
    assign consumed_char = got_r;
    assign consumed_valid = gotv_r;
    assign tx_char = tx_r;
    assign tx_valid = txv_r;
    assign printed_char = pr_r;
endmodule : ssc_far_end

// File: src/ssc_link_if.sv
// signals between the steering board and the logic board with its options
// assumes both ends run on the same clock; strobes are active high except chain_strobe_out_n and slot_occupied_divert_line_n
`timescale 1ns/1ps
interface ssc_link_if import ssc_pkg::*; ();
    // receive converter and shared receive path
    logic [CHAR_W-1:0] conv_char;
    logic conv_oe;
    logic conv_avail;
    logic [N_CHAIN-1:0][CHAR_W-1:0] slot_drv_char;
    logic [N_CHAIN-1:0] slot_drv_oe;
    logic [CHAR_W-1:0] slot_rx_char;
    logic [CHAR_W-1:0] cbuf_char;
    logic cbuf_avail;
    // strobe chain
    logic [N_CHAIN-1:0] slot_da;
    logic [N_CHAIN-1:0] slot_occupied_divert_line_n;
    logic [N_CHAIN-1:0] chain_strobe_out_n;
    logic char_consumed_ack;
    logic slot_ack;
    // substitution slot
    logic [CHAR_W-1:0] cbuf_out_char;
    logic [CHAR_W-1:0] slotf_in_char;
    logic [CHAR_W-1:0] slotf_out_char;
    logic slotf_fit_n;
    logic [CHAR_W-1:0] phead_char;
    // keyboard path
    logic [CHAR_W-1:0] kbd_char;
    logic kbd_strobe;
    logic [CHAR_W-1:0] lb_char;
    logic lb_strobe;
    logic [CHAR_W-1:0] mon_char;
    logic mon_strobe;
    logic ser_fit_n;
    logic [CHAR_W-1:0] ser_in_char;
    logic ser_in_strobe;
    logic [CHAR_W-1:0] ser_out_char;
    logic ser_out_strobe;

    modport dev (
        input conv_char, conv_oe, conv_avail, slot_drv_char, slot_drv_oe,
        input slot_occupied_divert_line_n, chain_strobe_out_n, char_consumed_ack,
        input cbuf_out_char, slotf_out_char, slotf_fit_n,
        input kbd_char, kbd_strobe, ser_fit_n, ser_out_char, ser_out_strobe,
        output slot_rx_char, cbuf_char, cbuf_avail, slot_da, slot_ack,
        output slotf_in_char, phead_char, lb_char, lb_strobe, mon_char, mon_strobe,
        output ser_in_char, ser_in_strobe
    );
    modport far (
        output conv_char, conv_oe, conv_avail, slot_drv_char, slot_drv_oe,
        output slot_occupied_divert_line_n, chain_strobe_out_n, char_consumed_ack,
        output cbuf_out_char, slotf_out_char, slotf_fit_n,
        output kbd_char, kbd_strobe, ser_fit_n, ser_out_char, ser_out_strobe,
        input slot_rx_char, cbuf_char, cbuf_avail, slot_da, slot_ack,
        input slotf_in_char, phead_char, lb_char, lb_strobe, mon_char, mon_strobe,
        input ser_in_char, ser_in_strobe
    );
endinterface : ssc_link_if

// File: src/ssc_pkg.sv
// shared constants, types and slot numbering for the option slot steering chain
// assumes one 100 MHz clock and a synchronous active-high reset at both ends
package ssc_pkg;
    localparam int CHAR_W = 8;
    localparam int N_CHAIN = 4;
    // chain positions in strobe order
    localparam int SL_E = 0;
    localparam int SL_D = 1;
    localparam int SL_A = 2;
    localparam int SL_B = 3;
    // set bit: position steered by chain output grounding (method two)
    localparam logic [N_CHAIN-1:0] METHOD2_DEF = 4'ha;
    localparam int CLK_NS = 10;
    localparam int OPT_DELAY_NS = 100;
    localparam logic [7:0] OPT_DELAY_CYC = 8'((OPT_DELAY_NS + CLK_NS - 1) / CLK_NS);
    localparam int ACK_NS = 50;
    localparam logic [7:0] ACK_CYC = 8'((ACK_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CHAR_W-1:0] CH_CR = 8'h0d;
    localparam logic [CHAR_W-1:0] CH_LF = 8'h0a;
    localparam logic [CHAR_W-1:0] SUBST_MASK = 8'h80;
    localparam logic [CHAR_W-1:0] CHAR_ZERO = 8'h00;
    typedef enum logic [1:0] {INS_IDLE, INS_PASS, INS_GAP, INS_DRIVE} ssc_ins_st_t;
endpackage : ssc_pkg

// File: src/ssc_steer_dev.sv
// steering board: receive broadcast, strobe daisy chain, keyboard routing,
// substitution slot routing
// assumes slot lines are synchronous to ref_clk and change only with boards fitted
`timescale 1ns/1ps
module ssc_steer_dev import ssc_pkg::*; #(
    parameter logic [N_CHAIN-1:0] METHOD2 = METHOD2_DEF
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // logic board and slots
    ssc_link_if.dev lk,
    // steering status
    output logic [N_CHAIN-1:0] chain_fitted,
    output logic ser_active,
    output logic subst_active,
    output logic rx_driven_by_slot
);
    // fitted test for one chain position
    function automatic logic pos_fitted(input logic m2, input logic div_n,
                                        input logic cho_n);
        if (m2)
            return ~cho_n;
        return ~div_n;
    endfunction : pos_fitted

    // strobe leaving one chain position
    function automatic logic pos_next(input logic m2, input logic fit, input logic inb,
                                      input logic div_n, input logic cho_n);
        if (!fit)
            return inb;
        if (m2)
            return ~div_n;
        return ~cho_n;
    endfunction : pos_next

    logic [N_CHAIN:0] link;
    logic [N_CHAIN-1:0] fit;
    logic [CHAR_W-1:0] bus_val;
    logic bus_slot;
    logic bus_any;

    logic [CHAR_W-1:0] rx_char_r;
    logic [CHAR_W-1:0] rx_char_nxt;
    logic cbuf_avail_r;
    logic cbuf_avail_nxt;
    logic [N_CHAIN-1:0] slot_da_r;
    logic [N_CHAIN-1:0] slot_da_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [N_CHAIN-1:0] fit_r;
    logic [N_CHAIN-1:0] fit_nxt;
    logic bus_slot_r;
    logic bus_slot_nxt;

    logic [CHAR_W-1:0] slotf_in_r;
    logic [CHAR_W-1:0] slotf_in_nxt;
    logic [CHAR_W-1:0] phead_r;
    logic [CHAR_W-1:0] phead_nxt;
    logic subst_r;
    logic subst_nxt;

    logic [CHAR_W-1:0] lb_char_r;
    logic [CHAR_W-1:0] lb_char_nxt;
    logic lb_strobe_r;
    logic lb_strobe_nxt;
    logic [CHAR_W-1:0] mon_char_r;
    logic [CHAR_W-1:0] mon_char_nxt;
    logic mon_strobe_r;
    logic mon_strobe_nxt;
    logic [CHAR_W-1:0] ser_in_char_r;
    logic [CHAR_W-1:0] ser_in_char_nxt;
    logic ser_in_strobe_r;
    logic ser_in_strobe_nxt;
    logic ser_r;
    logic ser_nxt;

    // receive path and strobe chain
    always_comb begin
        bus_val = lk.conv_char;
        bus_slot = 1'b0;
        bus_any = lk.conv_oe;
        for (int i = 0; i < N_CHAIN; i++) begin
            if (lk.slot_drv_oe[i]) begin
                bus_val = lk.slot_drv_char[i];
                bus_slot = 1'b1;
                bus_any = 1'b1;
            end
        end
        // undriven path keeps the last character rather than floating
        // tap before character buffer
        rx_char_nxt = bus_any ? bus_val : rx_char_r;
        bus_slot_nxt = bus_slot;
        // chain order E D A B
        link[0] = lk.conv_avail;
        for (int i = 0; i < N_CHAIN; i++) begin
            fit[i] = pos_fitted(METHOD2[i], lk.slot_occupied_divert_line_n[i],
                                lk.chain_strobe_out_n[i]);
            slot_da_nxt[i] = fit[i] & link[i];
            link[i+1] = pos_next(METHOD2[i], fit[i], link[i],
                                 lk.slot_occupied_divert_line_n[i],
                                 lk.chain_strobe_out_n[i]);
        end
        fit_nxt = fit;
        cbuf_avail_nxt = link[N_CHAIN];
        ack_nxt = lk.char_consumed_ack;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rx_char_r <= CHAR_ZERO;
            cbuf_avail_r <= 1'b0;
            slot_da_r <= '0;
            ack_r <= 1'b0;
            fit_r <= '0;
            bus_slot_r <= 1'b0;
        end else begin
            rx_char_r <= rx_char_nxt;
            cbuf_avail_r <= cbuf_avail_nxt;
            slot_da_r <= slot_da_nxt;
            ack_r <= ack_nxt;
            fit_r <= fit_nxt;
            bus_slot_r <= bus_slot_nxt;
        end
    end

    // substitution slot
    always_comb begin
        slotf_in_nxt = lk.cbuf_out_char;
        subst_nxt = ~lk.slotf_fit_n;
        // empty F slot would leave the print head undriven, so bypass it
        // F output to print
        phead_nxt = subst_nxt ? lk.slotf_out_char : lk.cbuf_out_char;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            slotf_in_r <= CHAR_ZERO;
            phead_r <= CHAR_ZERO;
            subst_r <= 1'b0;
        end else begin
            slotf_in_r <= slotf_in_nxt;
            phead_r <= phead_nxt;
            subst_r <= subst_nxt;
        end
    end

    // keyboard path
    always_comb begin
        ser_nxt = ~lk.ser_fit_n;
        mon_char_nxt = lk.kbd_char;
        mon_strobe_nxt = lk.kbd_strobe;
        ser_in_char_nxt = lk.kbd_char;
        ser_in_strobe_nxt = 1'b0;
        if (ser_nxt) begin
            ser_in_strobe_nxt = lk.kbd_strobe;
            lb_char_nxt = lk.ser_out_char;
            lb_strobe_nxt = lk.ser_out_strobe;
        end else begin
            lb_char_nxt = lk.kbd_char;
            lb_strobe_nxt = lk.kbd_strobe;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            lb_char_r <= CHAR_ZERO;
            lb_strobe_r <= 1'b0;
            mon_char_r <= CHAR_ZERO;
            mon_strobe_r <= 1'b0;
            ser_in_char_r <= CHAR_ZERO;
            ser_in_strobe_r <= 1'b0;
            ser_r <= 1'b0;
        end else begin
            lb_char_r <= lb_char_nxt;
            lb_strobe_r <= lb_strobe_nxt;
            mon_char_r <= mon_char_nxt;
            mon_strobe_r <= mon_strobe_nxt;
            ser_in_char_r <= ser_in_char_nxt;
            ser_in_strobe_r <= ser_in_strobe_nxt;
            ser_r <= ser_nxt;
        end
    end

    assign lk.slot_rx_char = rx_char_r;
    assign lk.cbuf_char = rx_char_r;
    assign lk.cbuf_avail = cbuf_avail_r;
    assign lk.slot_da = slot_da_r;
    assign lk.slot_ack = ack_r;
    assign lk.slotf_in_char = slotf_in_r;
    assign lk.phead_char = phead_r;
    assign lk.lb_char = lb_char_r;
    assign lk.lb_strobe = lb_strobe_r;
    assign lk.mon_char = mon_char_r;
    assign lk.mon_strobe = mon_strobe_r;
    assign lk.ser_in_char = ser_in_char_r;
    assign lk.ser_in_strobe = ser_in_strobe_r;
    assign chain_fitted = fit_r;
    assign ser_active = ser_r;
    assign subst_active = subst_r;
    assign rx_driven_by_slot = bus_slot_r;
endmodule : ssc_steer_dev

// File: tb/ssc_link_asserts.sv
// checker: steering board paths as seen on the link between the two ends
// assumes one clock, srst synchronous active high, every path one cycle late
`timescale 1ns/1ps
module ssc_link_asserts import ssc_pkg::*; #(
    parameter logic [N_CHAIN-1:0] METHOD2 = METHOD2_DEF
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // shared receive path
    input wire logic [CHAR_W-1:0] conv_char, slot_rx_char, cbuf_char,
    input wire logic conv_oe, conv_avail, cbuf_avail,
    input wire logic [N_CHAIN-1:0][CHAR_W-1:0] slot_drv_char,
    input wire logic [N_CHAIN-1:0] slot_drv_oe, slot_da,
    // strobe chain lines
    input wire logic [N_CHAIN-1:0] slot_occupied_divert_line_n, chain_strobe_out_n,
    // substitution slot
    input wire logic [CHAR_W-1:0] cbuf_out_char, slotf_in_char, slotf_out_char, phead_char,
    input wire logic slotf_fit_n,
    // keyboard path
    input wire logic [CHAR_W-1:0] kbd_char, lb_char, mon_char, ser_in_char, ser_out_char,
    input wire logic kbd_strobe, lb_strobe, mon_strobe, ser_fit_n, ser_in_strobe,
    input wire logic ser_out_strobe
);
    logic srst_d_r;
    logic srst_d_nxt;
    logic chain_end;

    // walk E, D, A, B; a fitted position replaces the strobe
    always_comb begin
        chain_end = conv_avail;
        for (int i = 0; i < N_CHAIN; i++) begin
            if (METHOD2[i] && !chain_strobe_out_n[i]) begin
                chain_end = ~slot_occupied_divert_line_n[i];
            end else if (!METHOD2[i] && !slot_occupied_divert_line_n[i]) begin
                chain_end = ~chain_strobe_out_n[i];
            end
        end
        srst_d_nxt = srst;
    end

    // inputs from the reset cycle are not judged
    always_ff @(posedge ref_clk) begin
        srst_d_r <= srst_d_nxt;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_key_ser;
        !srst_d_r && !ser_fit_n && kbd_strobe;
    endsequence
    sequence s_back_ser;
        !srst_d_r && !ser_fit_n && ser_out_strobe;
    endsequence

    property p_rx_conv;
        !srst_d_r && conv_oe && slot_drv_oe == '0 |=>
            slot_rx_char == $past(conv_char) && cbuf_char == $past(conv_char);
    endproperty
    a_rx_conv: assert property (p_rx_conv) else $error("converter char lost");
    property p_rx_slot;
        !srst_d_r && slot_drv_oe[SL_B] |=> cbuf_char == $past(slot_drv_char[SL_B]);
    endproperty
    a_rx_slot: assert property (p_rx_slot) else $error("option char lost");
    property p_subst;
        !srst_d_r |=> slotf_in_char == $past(cbuf_out_char) && phead_char ==
            ($past(slotf_fit_n) ? $past(cbuf_out_char) : $past(slotf_out_char));
    endproperty
    a_subst: assert property (p_subst) else $error("print head char wrong");
    property p_kbd_pass;
        !srst_d_r && ser_fit_n |=> lb_strobe == $past(kbd_strobe)
            && (!lb_strobe || lb_char == $past(kbd_char));
    endproperty
    a_kbd_pass: assert property (p_kbd_pass) else $error("key not passed");
    property p_kbd_mon;
        !srst_d_r && kbd_strobe |=> mon_strobe && mon_char == $past(kbd_char);
    endproperty
    a_kbd_mon: assert property (p_kbd_mon) else $error("key not monitored");
    property p_ser_in;
        s_key_ser |=> ser_in_strobe && ser_in_char == $past(kbd_char);
    endproperty
    a_ser_in: assert property (p_ser_in) else $error("key not sent to series");
    property p_ser_out;
        s_back_ser |=> lb_strobe && lb_char == $past(ser_out_char);
    endproperty
    a_ser_out: assert property (p_ser_out) else $error("series char not passed");
    property p_ser_only;
        !srst_d_r && !ser_fit_n |=> lb_strobe == $past(ser_out_strobe);
    endproperty
    a_ser_only: assert property (p_ser_only) else $error("key bypassed series");
    property p_chain;
        !srst_d_r |=> cbuf_avail == $past(chain_end);
    endproperty
    a_chain: assert property (p_chain) else $error("chain end wrong");
    property p_div_e;
        !srst_d_r && !slot_occupied_divert_line_n[SL_E] |=> slot_da[SL_E] == $past(conv_avail);
    endproperty
    a_div_e: assert property (p_div_e) else $error("strobe not diverted");
endmodule : ssc_link_asserts

// File: tb/testbench.sv
// bench: pair a has options at E, B and the series slot; pair b only slot F
// assumes far end option timing as handed over; both pairs get the same stimulus
`timescale 1ns/1ps
module testbench import ssc_pkg::*;;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [CHAR_W-1:0] rx_char_in = 8'h00;
    logic [CHAR_W-1:0] kbd_in = 8'h00;
    logic rx_valid = 1'b0;
    logic kbd_valid = 1'b0;
    logic [CHAR_W-1:0] cons_a, cons_b, tx_a, tx_b, prn_a, prn_b, pa, pb;
    logic cv_a, cv_b, tv_a, tv_b, sa_a, sa_b, su_a, su_b, dr_a, dr_b;
    // option drive seen on the shared path since the last received char
    logic seen_a = 1'b0;
    logic seen_b = 1'b0;
    logic [N_CHAIN-1:0] fit_a, fit_b;
    logic [CHAR_W-1:0] q_rx_a[$], q_rx_b[$], q_tx_a[$], q_tx_b[$];
    int mismatches = 0;
    int total_checks = 0;

    always #5 ref_clk = ~ref_clk;

    ssc_link_if lk_a ();
    ssc_link_if lk_b ();
    ssc_steer_dev ssc_steer_dev_inst (.ref_clk(ref_clk), .srst(srst), .lk(lk_a.dev),
        .chain_fitted(fit_a), .ser_active(sa_a), .subst_active(su_a), .rx_driven_by_slot(dr_a));
    ssc_steer_dev ssc_steer_dev_inst_b (.ref_clk(ref_clk), .srst(srst), .lk(lk_b.dev),
        .chain_fitted(fit_b), .ser_active(sa_b), .subst_active(su_b), .rx_driven_by_slot(dr_b));
    ssc_far_end ssc_far_end_inst (.ref_clk(ref_clk), .srst(srst), .lk(lk_a.far),
        .rx_char_in(rx_char_in), .rx_valid(rx_valid), .kbd_in(kbd_in), .kbd_valid(kbd_valid),
        .consumed_char(cons_a), .consumed_valid(cv_a), .tx_char(tx_a), .tx_valid(tv_a),
        .printed_char(prn_a));
    ssc_far_end #(.FIT_E(1'b0), .FIT_B(1'b0), .FIT_SER(1'b0), .FIT_F(1'b1))
        ssc_far_end_inst_b (.ref_clk(ref_clk), .srst(srst), .lk(lk_b.far),
        .rx_char_in(rx_char_in), .rx_valid(rx_valid), .kbd_in(kbd_in), .kbd_valid(kbd_valid),
        .consumed_char(cons_b), .consumed_valid(cv_b), .tx_char(tx_b), .tx_valid(tv_b),
        .printed_char(prn_b));
    ssc_link_asserts ssc_link_asserts_inst (.ref_clk(ref_clk), .srst(srst),
        .conv_char(lk_a.conv_char), .slot_rx_char(lk_a.slot_rx_char),
        .cbuf_char(lk_a.cbuf_char), .conv_oe(lk_a.conv_oe), .conv_avail(lk_a.conv_avail),
        .cbuf_avail(lk_a.cbuf_avail), .slot_drv_char(lk_a.slot_drv_char),
        .slot_drv_oe(lk_a.slot_drv_oe), .slot_da(lk_a.slot_da),
        .slot_occupied_divert_line_n(lk_a.slot_occupied_divert_line_n),
        .chain_strobe_out_n(lk_a.chain_strobe_out_n), .cbuf_out_char(lk_a.cbuf_out_char),
        .slotf_in_char(lk_a.slotf_in_char), .slotf_out_char(lk_a.slotf_out_char),
        .phead_char(lk_a.phead_char), .slotf_fit_n(lk_a.slotf_fit_n),
        .kbd_char(lk_a.kbd_char), .lb_char(lk_a.lb_char), .mon_char(lk_a.mon_char),
        .ser_in_char(lk_a.ser_in_char), .ser_out_char(lk_a.ser_out_char),
        .kbd_strobe(lk_a.kbd_strobe), .lb_strobe(lk_a.lb_strobe),
        .mon_strobe(lk_a.mon_strobe), .ser_fit_n(lk_a.ser_fit_n),
        .ser_in_strobe(lk_a.ser_in_strobe), .ser_out_strobe(lk_a.ser_out_strobe));

    task automatic close_out();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task automatic cmp_char(input logic [CHAR_W-1:0] got, input logic [CHAR_W-1:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_char

    task automatic cmp_st(input logic [4:0] got, input logic [4:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_st

    // a result with no note pending is itself a mismatch
    task automatic chk_pop(input logic v, input logic [CHAR_W-1:0] got,
                           ref logic [CHAR_W-1:0] q[$]);
        if (v === 1'b1) begin
            if (q.size() == 0) begin
                mismatches++;
                $display("FAIL t=%0t got=%h exp=%h", $time, got, 8'h00);
            end else begin
                cmp_char(got, q.pop_front());
            end
        end
    endtask : chk_pop

    always @(negedge ref_clk) begin
        if (!srst) begin
            chk_pop(cv_a, cons_a, q_rx_a);
            chk_pop(cv_b, cons_b, q_rx_b);
            chk_pop(tv_a, tx_a, q_tx_a);
            chk_pop(tv_b, tx_b, q_tx_b);
            seen_a = seen_a | (dr_a === 1'b1);
            seen_b = seen_b | (dr_b === 1'b1);
        end
    end

    // waits for every note to be met, then for the acknowledge to clear
    task automatic settle();
        int n;
        n = 0;
        while (q_rx_a.size() + q_rx_b.size() + q_tx_a.size() + q_tx_b.size() > 0 && n < 600) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 600) begin
            mismatches++;
            close_out();
        end
        repeat (ACK_CYC + 4) @(negedge ref_clk);
    endtask : settle

    task automatic send_rx(input logic [CHAR_W-1:0] c);
        @(negedge ref_clk);
        rx_char_in = c;
        rx_valid = 1'b1;
        seen_a = 1'b0;
        seen_b = 1'b0;
        q_rx_a.push_back(c);
        q_rx_b.push_back(c);
        pa = c;
        pb = c ^ SUBST_MASK;
        if (c == CH_CR) begin
            q_rx_a.push_back(CH_LF);
            pa = CH_LF;
        end
        @(negedge ref_clk);
        rx_valid = 1'b0;
        settle();
        cmp_char(prn_a, pa);
        cmp_char(prn_b, pb);
        // only the inserting option at B ever takes the shared path
        cmp_st({3'h0, seen_a, seen_b}, {3'h0, c == CH_CR, 1'b0});
    endtask : send_rx

    task automatic send_kbd(input logic [CHAR_W-1:0] c);
        @(negedge ref_clk);
        kbd_in = c;
        kbd_valid = 1'b1;
        q_tx_a.push_back(c);
        q_tx_b.push_back(c);
        if (c == CH_CR) begin
            q_tx_a.push_back(CH_LF);
        end
        @(negedge ref_clk);
        kbd_valid = 1'b0;
        settle();
    endtask : send_kbd

    initial begin
        void'($urandom(32'h9681));
        repeat (5) @(negedge ref_clk);
        srst = 1'b0;
        repeat (3) @(negedge ref_clk);
        cmp_st({fit_a[3:2], fit_a[0], sa_a, su_a}, 5'h16);
        cmp_st({fit_b[3:2], fit_b[0], sa_b, su_b}, 5'h01);
        send_rx(CH_CR);
        send_kbd(CH_CR);
        for (int i = 0; i < 24; i++) begin
            send_rx(8'($urandom_range(126, 32)));
            send_kbd(8'($urandom_range(126, 32)));
        end
        send_rx(CH_CR);
        close_out();
    end
endmodule : testbench
